// >>> core/usrx_pkg.sv
// constants for the asynchronous receive block: register map, fields, resets, states
`default_nettype none
package usrx_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MODE = 4'h8;
    localparam logic [3:0] ADDR_MASK = 4'hC;
    // mode register fields
    localparam int MODE_FACT_LSB = 0;
    localparam int MODE_LEN_LSB = 2;
    localparam int MODE_PAR_EN = 4;
    localparam int MODE_PAR_EVEN = 5;
    localparam int MODE_W = 6;
    localparam logic [5:0] MODE_RESET = 6'h2E;
    localparam logic [1:0] FACT_1X = 2'h1;
    localparam logic [1:0] FACT_16X = 2'h2;
    localparam logic [1:0] FACT_64X = 2'h3;
    localparam logic [6:0] DIV_1X = 7'h01;
    localparam logic [6:0] DIV_16X = 7'h10;
    localparam logic [6:0] DIV_64X = 7'h40;
    localparam logic [2:0] LEN_BASE = 3'h4;
    // status bit positions, mask shares the layout
    localparam int ST_RXAV = 0;
    localparam int ST_PERR = 1;
    localparam int ST_FERR = 2;
    localparam int ST_OVR = 3;
    localparam int ST_BRK = 4;
    localparam int ST_W = 5;
    localparam logic [4:0] STAT_RESET = 5'h00;
    localparam logic [4:0] MASK_RESET = 5'h00;
    // host pacing and status latency, in system clock periods
    localparam int CMD_GAP_ASYNC_CY = 8;
    localparam int CMD_GAP_SYNC_CY = 18;
    localparam int STATUS_LAT_CY = 28;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PAR = 3'b011,
        RX_STOP = 3'b100,
        RX_BRK = 3'b101
    } usrx_state_t;
endpackage : usrx_pkg
`default_nettype wire

// >>> core/usrx_top.sv
// asynchronous receiver: start validation, break and parity flag behaviour, register port
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module usrx_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic receiver_bit_clock,
    input wire logic rxd,
    output logic rx_char_available,
    output logic irq
);
    logic rst_s1_r;
    logic rst_n;
    logic rxc_s1_r, rxc_s2_r, rxc_s3_r, rxc_q_r, rxc_prev_r;
    logic rxd_s1_r, rxd_s2_r, rxd_s3_r, rxd_q_r, rxd_prev_r;
    logic tick;
    logic line_rise;
    logic [5:0] mode_r;
    logic [4:0] mask_r;
    logic [4:0] stat_r;
    logic [4:0] ev_vec;
    logic [4:0] clr_vec;
    logic [7:0] rx_data_r;
    logic [7:0] shift_r;
    logic [7:0] rdata_r;
    logic irq_r;
    usrx_pkg::usrx_state_t state_r;
    logic [6:0] cnt_r;
    logic [6:0] ph_r;
    logic [2:0] bitn_r;
    logic zero_r;
    logic par_bit_r;
    logic ev_char_r, ev_early_r, ev_perr_r, ev_ferr_r, ev_ovr_r, ev_brk_r;
    logic [6:0] div;
    logic [6:0] half;
    logic [2:0] last_bit;
    logic par_bad;
    logic st_rd;
    logic dt_rd;

    // reset release through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // pin synchronisers: a change counts once the second and third stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxc_s1_r <= 1'b0;
            rxc_s2_r <= 1'b0;
            rxc_s3_r <= 1'b0;
            rxc_q_r <= 1'b0;
            rxc_prev_r <= 1'b0;
            rxd_s1_r <= 1'b1;
            rxd_s2_r <= 1'b1;
            rxd_s3_r <= 1'b1;
            rxd_q_r <= 1'b1;
            rxd_prev_r <= 1'b1;
        end else begin
            rxc_s1_r <= receiver_bit_clock;
            rxc_s2_r <= rxc_s1_r;
            rxc_s3_r <= rxc_s2_r;
            if (rxc_s2_r == rxc_s3_r) begin
                rxc_q_r <= rxc_s3_r;
            end
            rxc_prev_r <= rxc_q_r;
            rxd_s1_r <= rxd;
            rxd_s2_r <= rxd_s1_r;
            rxd_s3_r <= rxd_s2_r;
            if (rxd_s2_r == rxd_s3_r) begin
                rxd_q_r <= rxd_s3_r;
            end
            rxd_prev_r <= rxd_q_r;
        end
    end

    assign tick = rxc_q_r & ~rxc_prev_r;
    assign line_rise = rxd_q_r & ~rxd_prev_r;

    always_comb begin
        unique case (mode_r[usrx_pkg::MODE_FACT_LSB +: 2])
            usrx_pkg::FACT_16X: div = usrx_pkg::DIV_16X;
            usrx_pkg::FACT_64X: div = usrx_pkg::DIV_64X;
            default: div = usrx_pkg::DIV_1X;
        endcase
    end
    assign half = div >> 1;
    assign last_bit = usrx_pkg::LEN_BASE + {1'b0, mode_r[usrx_pkg::MODE_LEN_LSB +: 2]};
    // even parity expects the xor of the data; unused high bits are held at zero
    assign par_bad = mode_r[usrx_pkg::MODE_PAR_EN]
        & (par_bit_r != ((^shift_r) ^ ~mode_r[usrx_pkg::MODE_PAR_EVEN]));

    // receive sequencer; only async reception, the mode field picks the factor
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= usrx_pkg::RX_IDLE;
            cnt_r <= 7'h00;
            ph_r <= 7'h00;
            bitn_r <= 3'h0;
            zero_r <= 1'b1;
            par_bit_r <= 1'b0;
            shift_r <= 8'h00;
            ev_char_r <= 1'b0;
            ev_early_r <= 1'b0;
            ev_perr_r <= 1'b0;
            ev_ferr_r <= 1'b0;
            ev_ovr_r <= 1'b0;
            ev_brk_r <= 1'b0;
        end else begin
            ev_char_r <= 1'b0;
            ev_early_r <= 1'b0;
            ev_perr_r <= 1'b0;
            ev_ferr_r <= 1'b0;
            ev_ovr_r <= 1'b0;
            ev_brk_r <= 1'b0;
            if (line_rise && state_r == usrx_pkg::RX_PAR && zero_r) begin
                // a break lifting in this gap leaves a parity error and no data
                ev_perr_r <= 1'b1;
                state_r <= usrx_pkg::RX_IDLE;
            end else if (tick) begin
                unique case (state_r)
                    usrx_pkg::RX_IDLE: begin
                        if (!rxd_q_r) begin
                            shift_r <= 8'h00;
                            bitn_r <= 3'h0;
                            zero_r <= 1'b1;
                            par_bit_r <= 1'b0;
                            if (div == usrx_pkg::DIV_1X) begin
                                ph_r <= 7'h00;
                                state_r <= usrx_pkg::RX_DATA;
                            end else begin
                                cnt_r <= 7'h01;
                                state_r <= usrx_pkg::RX_START;
                            end
                        end
                    end
                    usrx_pkg::RX_START: begin
                        if (rxd_q_r) begin
                            if (cnt_r < half) begin
                                state_r <= usrx_pkg::RX_IDLE;
                            end else begin
                                // exact half bit: kept as the flawed path, flags early
                                ev_early_r <= 1'b1;
                                ph_r <= 7'h01;
                                state_r <= usrx_pkg::RX_DATA;
                            end
                        end else if (cnt_r == half) begin
                            ph_r <= 7'h01;
                            state_r <= usrx_pkg::RX_DATA;
                        end else begin
                            cnt_r <= cnt_r + 7'h01;
                        end
                    end
                    usrx_pkg::RX_DATA, usrx_pkg::RX_PAR, usrx_pkg::RX_STOP: begin
                        if (ph_r == div - 7'h01) begin
                            ph_r <= 7'h00;
                            if (state_r == usrx_pkg::RX_DATA) begin
                                shift_r[bitn_r] <= rxd_q_r;
                                zero_r <= zero_r & ~rxd_q_r;
                                bitn_r <= bitn_r + 3'h1;
                                if (bitn_r == last_bit) begin
                                    state_r <= mode_r[usrx_pkg::MODE_PAR_EN] ? usrx_pkg::RX_PAR
                                        : usrx_pkg::RX_STOP;
                                end
                            end else if (state_r == usrx_pkg::RX_PAR) begin
                                par_bit_r <= rxd_q_r;
                                state_r <= usrx_pkg::RX_STOP;
                            end else if (!rxd_q_r && zero_r && !par_bit_r) begin
                                // whole frame low: a break, wait for the line quietly
                                ev_brk_r <= 1'b1;
                                state_r <= usrx_pkg::RX_BRK;
                            end else begin
                                ev_char_r <= 1'b1;
                                ev_perr_r <= par_bad;
                                ev_ferr_r <= ~rxd_q_r;
                                ev_ovr_r <= stat_r[usrx_pkg::ST_RXAV];
                                state_r <= usrx_pkg::RX_IDLE;
                            end
                        end else begin
                            ph_r <= ph_r + 7'h01;
                        end
                    end
                    usrx_pkg::RX_BRK: begin
                        if (rxd_q_r) begin
                            state_r <= usrx_pkg::RX_IDLE;
                        end
                    end
                    default: begin
                        state_r <= usrx_pkg::RX_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_r <= 8'h00;
        end else if (ev_char_r) begin
            rx_data_r <= shift_r;
        end
    end

    // software side; commands may come back to back, the host keeps its own gap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= usrx_pkg::MODE_RESET;
            mask_r <= usrx_pkg::MASK_RESET;
        end else if (wr) begin
            if (addr == usrx_pkg::ADDR_MODE) begin
                mode_r <= wdata[usrx_pkg::MODE_W-1:0];
            end
            if (addr == usrx_pkg::ADDR_MASK) begin
                mask_r <= wdata[usrx_pkg::ST_W-1:0];
            end
        end
    end

    assign st_rd = rd && addr == usrx_pkg::ADDR_STATUS;
    // a data read with nothing available just returns the old byte
    assign dt_rd = rd && addr == usrx_pkg::ADDR_DATA;
    assign ev_vec = {ev_brk_r, ev_ovr_r, ev_ferr_r, ev_perr_r, ev_char_r | ev_early_r};
    assign clr_vec = {st_rd, st_rd, st_rd, st_rd, dt_rd};

    // sticky flags: an event in the clearing cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < usrx_pkg::ST_W; gi++) begin : g_stat
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stat_r[gi] <= usrx_pkg::STAT_RESET[gi];
                end else if (ev_vec[gi]) begin
                    stat_r[gi] <= 1'b1;
                end else if (clr_vec[gi]) begin
                    stat_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_r & mask_r);
            if (rd) begin
                unique case (addr)
                    usrx_pkg::ADDR_DATA: rdata_r <= rx_data_r;
                    usrx_pkg::ADDR_STATUS: rdata_r <= {3'h0, stat_r};
                    usrx_pkg::ADDR_MODE: rdata_r <= {2'h0, mode_r};
                    usrx_pkg::ADDR_MASK: rdata_r <= {3'h0, mask_r};
                    default: rdata_r <= 8'h00;
                endcase
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    assign rdata = rdata_r;
    assign irq = irq_r;
    assign rx_char_available = stat_r[usrx_pkg::ST_RXAV];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_defect_seen;
        state_r == usrx_pkg::RX_START && tick && rxd_q_r && cnt_r == half && div != usrx_pkg::DIV_1X;
    endsequence
    sequence s_early_flag;
        ev_early_r ##1 stat_r[usrx_pkg::ST_RXAV];
    endsequence

    a_short_start_drop: assert property (state_r == usrx_pkg::RX_START && tick && rxd_q_r && cnt_r < half
        |=> state_r == usrx_pkg::RX_IDLE && !ev_early_r)
        else $error("short start pulse not discarded");
    a_valid_start_go: assert property (state_r == usrx_pkg::RX_START && tick && !rxd_q_r && cnt_r == half
        |=> state_r == usrx_pkg::RX_DATA && ph_r == 7'h01)
        else $error("valid start not accepted");
    a_defect_early_flag: assert property (s_defect_seen |=> s_early_flag)
        else $error("half-bit start did not flag data early");
    a_break_end_perr: assert property (line_rise && state_r == usrx_pkg::RX_PAR && zero_r
        |=> ev_perr_r && !ev_char_r ##1 stat_r[usrx_pkg::ST_PERR])
        else $error("break end before parity mishandled");
    a_perr_sticky: assert property (stat_r[usrx_pkg::ST_PERR] && !st_rd |=> stat_r[usrx_pkg::ST_PERR])
        else $error("parity error dropped without status read");
    a_break_quiet: assert property (state_r == usrx_pkg::RX_BRK |-> !ev_char_r && !ev_perr_r)
        else $error("break set data or parity flag");
    a_bad_parity_both: assert property (tick && state_r == usrx_pkg::RX_STOP && ph_r == div - 7'h01
        && (rxd_q_r || !zero_r || par_bit_r) && par_bad |=> ev_char_r && ev_perr_r)
        else $error("bad parity char missing a flag");
    a_direct_sample_1x: assert property (div == usrx_pkg::DIV_1X && tick && state_r == usrx_pkg::RX_IDLE
        && !rxd_q_r |=> state_r == usrx_pkg::RX_DATA)
        else $error("1x start not taken directly");
    a_status_latency: assert property ($rose(rxd_q_r) && state_r == usrx_pkg::RX_PAR && zero_r
        && !tick |-> ##[1:3] stat_r[usrx_pkg::ST_PERR])
        else $error("status flag late");
    a_irq_follows: assert property (stat_r[usrx_pkg::ST_BRK] && mask_r[usrx_pkg::ST_BRK] && !st_rd
        ##1 stat_r[usrx_pkg::ST_BRK] |-> irq_r)
        else $error("masked-in flag without interrupt");
endmodule : usrx_top
`default_nettype wire

// >>> tb/usrx_tx_model.sv
// remote serial transmitter model: free running receiver clock and frames on the receive line
`timescale 1ns/1ps
`default_nettype none
module usrx_tx_model (
    output var logic receiver_bit_clock,
    output var logic rxd,
    output var logic stop_mid
);
    // frame format, set by the bench to match the mode it has written
    int nbits = 8;
    logic par_on = 1'b1;
    logic par_even = 1'b0;
    logic stop_lvl = 1'b1;
    // the baud clock runs free, start validation needs ticks while the line idles
    initial begin
        receiver_bit_clock = 1'b0;
        rxd = 1'b1;
        stop_mid = 1'b0;
        #3;
        forever #40 receiver_bit_clock = ~receiver_bit_clock;
    end
    // line moves on the falling edge so every tick sees a settled level
    task automatic hold(input logic v, input int n);
        @(negedge receiver_bit_clock);
        rxd = v;
        repeat (n) @(posedge receiver_bit_clock);
    endtask : hold
    // lsb first, nbits data, optional parity, one stop bit; bad flips the parity bit
    task automatic frame(input logic [7:0] d, input int st, input int div, input logic bad);
        logic [7:0] m;
        m = d & (8'hFF >> (8 - nbits));
        hold(1'b0, st);
        for (int i = 0; i < nbits; i++) hold(d[i], div);
        if (par_on) hold(^m ^ ~par_even ^ bad, div);
        hold(stop_lvl, div / 2 + 1);
        stop_mid = 1'b1;
        #10 stop_mid = 1'b0;
        hold(1'b1, 2 * div);
    endtask : frame
endmodule : usrx_tx_model
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the asynchronous receiver
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk;
    logic nrst;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic receiver_bit_clock;
    logic rxd;
    logic rx_char_available;
    logic irq;
    logic stop_mid;
    int fails = 0;
    int check_count = 0;
    realtime t_mid;
    realtime t_av;
    usrx_top dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .receiver_bit_clock(receiver_bit_clock), .rxd(rxd), .rx_char_available(rx_char_available), .irq(irq));
    usrx_tx_model tx_u (.receiver_bit_clock(receiver_bit_clock), .rxd(rxd), .stop_mid(stop_mid));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge stop_mid) t_mid = $realtime;
    always @(posedge rx_char_available) t_av = $realtime;
    task automatic wrap_up;
        $display("fails=%0d check_count=%0d", fails, check_count);
        if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    // mode, mask and one unmapped address are written: no transmitter here, so the data address is never written
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        repeat (usrx_pkg::CMD_GAP_ASYNC_CY) @(posedge clk);
    endtask : wr_reg
    // read data stand only in the cycle after the strobe, so they are taken mid-cycle
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string m);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e, m);
    endtask : rd_chk
    task automatic wait_av(input int n);
        for (int i = 0; i < n && rx_char_available !== 1'b1; i++) @(posedge clk);
    endtask : wait_av
    task automatic t_reset;
        rd_chk(usrx_pkg::ADDR_MODE, {2'h0, usrx_pkg::MODE_RESET}, "mode reset");
        rd_chk(usrx_pkg::ADDR_STATUS, {3'h0, usrx_pkg::STAT_RESET}, "status reset");
        rd_chk(usrx_pkg::ADDR_MASK, {3'h0, usrx_pkg::MASK_RESET}, "mask reset");
        wr_reg(4'h2, 8'hFF);
        rd_chk(4'h2, 8'h00, "unmapped");
    endtask : t_reset
    task automatic t_good;
        logic [7:0] md [4] = '{8'h1E, 8'h1E, 8'h1F, 8'h1F};
        int st [4] = '{16, 12, 64, 40};
        logic [7:0] dv [4] = '{8'hA5, 8'h01, 8'h80, 8'h5A};
        realtime lat_max = usrx_pkg::STATUS_LAT_CY * 10.0;
        for (int i = 0; i < 4; i++) begin
            wr_reg(usrx_pkg::ADDR_MODE, md[i]);
            wr_reg(usrx_pkg::ADDR_MASK, 8'h01);
            t_av = 0.0;
            tx_u.frame(dv[i], st[i], md[i][0] ? 64 : 16, 1'b0);
            if (st[i] == 16) chk({7'h00, t_av > 0.0 && t_av - t_mid <= lat_max}, 8'h01, "flag latency");
            chk({7'h00, irq}, 8'h01, "irq set");
            rd_chk(usrx_pkg::ADDR_DATA, dv[i], "data");
            @(negedge clk);
            chk({6'h00, irq, rx_char_available}, 8'h00, "data read clears");
        end
    endtask : t_good
    task automatic t_short;
        wr_reg(usrx_pkg::ADDR_MODE, 8'h1E);
        tx_u.hold(1'b0, 6);
        tx_u.hold(1'b1, 200);
        wr_reg(usrx_pkg::ADDR_MODE, 8'h1F);
        tx_u.hold(1'b0, 30);
        tx_u.hold(1'b1, 800);
        rd_chk(usrx_pkg::ADDR_STATUS, 8'h00, "short pulse");
    endtask : t_short
    task automatic t_eight;
        wr_reg(usrx_pkg::ADDR_MODE, 8'h1E);
        tx_u.hold(1'b0, 8);
        tx_u.hold(1'b1, 1);
        // a whole frame needs eleven bit times, so a flag inside four is early
        wait_av(500);
        chk({7'h00, rx_char_available}, 8'h01, "early flag");
        tx_u.hold(1'b1, 200);
        rd_chk(usrx_pkg::ADDR_DATA, 8'hFF, "misaligned data");
        rd_chk(usrx_pkg::ADDR_STATUS, 8'h08, "overrun after misread");
    endtask : t_eight
    task automatic t_break;
        wr_reg(usrx_pkg::ADDR_MODE, 8'h1E);
        wr_reg(usrx_pkg::ADDR_MASK, 8'h12);
        tx_u.hold(1'b0, 144);
        tx_u.hold(1'b1, 64);
        chk({6'h00, irq, rx_char_available}, 8'h02, "break in parity");
        tx_u.frame(8'h3C, 16, 16, 1'b0);
        rd_chk(usrx_pkg::ADDR_STATUS, 8'h03, "parity kept");
        rd_chk(usrx_pkg::ADDR_DATA, 8'h3C, "data after break");
        tx_u.hold(1'b0, 240);
        tx_u.hold(1'b1, 48);
        chk({6'h00, irq, rx_char_available}, 8'h02, "break irq");
        rd_chk(usrx_pkg::ADDR_STATUS, 8'h10, "long break");
        rd_chk(usrx_pkg::ADDR_STATUS, 8'h00, "status cleared");
    endtask : t_break
    task automatic t_bad_par;
        wr_reg(usrx_pkg::ADDR_MASK, 8'h00);
        tx_u.frame(8'h96, 16, 16, 1'b1);
        chk({7'h00, irq}, 8'h00, "masked irq");
        rd_chk(usrx_pkg::ADDR_STATUS, 8'h03, "bad parity");
        rd_chk(usrx_pkg::ADDR_DATA, 8'h96, "bad parity data");
    endtask : t_bad_par
    task automatic t_formats;
        wr_reg(usrx_pkg::ADDR_MODE, 8'h3A);
        tx_u.nbits = 7;
        tx_u.par_even = 1'b1;
        tx_u.frame(8'h6B, 16, 16, 1'b1);
        rd_chk(usrx_pkg::ADDR_STATUS, 8'h03, "7 bit even parity");
        rd_chk(usrx_pkg::ADDR_DATA, 8'h6B, "7 bit data");
        // five bits, no parity, stop held low: a framing error beside the data
        wr_reg(usrx_pkg::ADDR_MODE, 8'h02);
        tx_u.nbits = 5;
        tx_u.par_on = 1'b0;
        tx_u.stop_lvl = 1'b0;
        tx_u.frame(8'h15, 16, 16, 1'b0);
        rd_chk(usrx_pkg::ADDR_STATUS, 8'h05, "5 bit framing");
        rd_chk(usrx_pkg::ADDR_DATA, 8'h15, "5 bit data");
        tx_u.nbits = 8;
        tx_u.par_on = 1'b1;
        tx_u.par_even = 1'b0;
        tx_u.stop_lvl = 1'b1;
    endtask : t_formats
    task automatic t_one_x;
        wr_reg(usrx_pkg::ADDR_MODE, 8'h1D);
        tx_u.hold(1'b1, 4);
        tx_u.frame(8'hC3, 1, 1, 1'b0);
        tx_u.hold(1'b1, 4);
        rd_chk(usrx_pkg::ADDR_STATUS, 8'h01, "1x status");
        rd_chk(usrx_pkg::ADDR_DATA, 8'hC3, "1x data");
    endtask : t_one_x
    initial begin
        nrst = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_good;
        t_short;
        t_eight;
        t_break;
        t_bad_par;
        t_formats;
        t_one_x;
        wrap_up;
    end
    // longest path is about forty thousand cycles
    initial begin
        #900000;
        fails++;
        wrap_up;
    end
endmodule : tb_top
`default_nettype wire
